// ### rtl/pio_pkg.sv
// Package for the parallel I/O port: offsets, reset values, carrier structs.
// Assumes a single 100 MHz clock domain and no bus wrapper around the port.
`default_nettype none
package pio_pkg;
    // ==========================================================
    // Port geometry
    localparam int PIO_W = 16;
    // Pins present on this port; absent pins read as zero
    localparam logic [15:0] PIO_IMPL_MASK = 16'hffff;
    // Pins able to carry change notification
    localparam logic [15:0] PIO_CN_MASK = 16'hffff;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] PIO_OFF_DIR = 8'h00;
    localparam logic [7:0] PIO_OFF_LVL = 8'h10;
    localparam logic [7:0] PIO_OFF_HOLD = 8'h20;
    localparam logic [7:0] PIO_OFF_ODS = 8'h30;
    localparam logic [7:0] PIO_OFF_ADS = 8'h40;
    localparam logic [7:0] PIO_OFF_CNEN = 8'h50;
    localparam logic [7:0] PIO_OFF_PUE = 8'h60;
    localparam logic [7:0] PIO_OFF_CNPEND = 8'h70;
    // Alias offsets above each base register
    localparam logic [3:0] PIO_ALIAS_BASE = 4'h0;
    localparam logic [3:0] PIO_ALIAS_CLR = 4'h4;
    localparam logic [3:0] PIO_ALIAS_SET = 4'h8;
    localparam logic [3:0] PIO_ALIAS_INV = 4'hc;
    // ==========================================================
    // Reset values
    localparam logic [15:0] PIO_RST_DIR = 16'hffff;
    localparam logic [15:0] PIO_RST_HOLD = 16'h0000;
    localparam logic [15:0] PIO_RST_ODS = 16'h0000;
    localparam logic [15:0] PIO_RST_ADS = 16'h0000;
    localparam logic [15:0] PIO_RST_CNEN = 16'h0000;
    localparam logic [15:0] PIO_RST_PUE = 16'h0000;
    localparam logic [15:0] PIO_RST_ZERO = 16'h0000;
    localparam logic [15:0] PIO_ALIAS_RDATA = 16'h0000;
    // ==========================================================
    // Carriers
    typedef enum logic [1:0] {PIO_OP_WRITE, PIO_OP_CLR, PIO_OP_SET, PIO_OP_INV} pio_op_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pio_req_t;
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
        logic [15:0] pullup_en;
    } pio_pad_t;
endpackage : pio_pkg
`default_nettype wire

// ### rtl/pio_reg_bit.sv
// One base register with clear, set and toggle aliases.
// Assumes the caller decodes the register and operation from the address.
`default_nettype none
module pio_reg_bit
    import pio_pkg::*;
#(
    parameter logic [15:0] RST = 16'h0000,
    parameter logic [15:0] MASK = 16'hffff
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Update
    input wire logic we,
    input wire pio_op_t op,
    input wire logic [15:0] wdata,
    // State
    output logic [15:0] value_q
);
    logic [15:0] value_d;

    // ==========================================================
    // Alias bit operations
    always_comb begin
        value_d = value_q;
        if (we) begin
            case (op)
                PIO_OP_WRITE: value_d = wdata;
                PIO_OP_CLR: value_d = value_q & ~wdata;
                PIO_OP_SET: value_d = value_q | wdata;
                default: value_d = value_q ^ wdata;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            value_q <= RST & MASK;
        end else begin
            value_q <= value_d & MASK;
        end
    end
endmodule : pio_reg_bit
`default_nettype wire

// ### rtl/pio_port.sv
// Parallel I/O port: direction, output hold, pin level, open drain,
// analog select, change notification with pull-ups.
// Assumes a same-clock register request port and asynchronous pad inputs.
`default_nettype none
// Operation
// - Direction bit 1 input, 0 output
// - Reset sets every direction bit: inputs
// - Pin level read returns synchronized pins
// - Pin level write updates output hold
// - Hold read returns last written value
// - Unimplemented pins read as zero
// - Clear/set/toggle aliases touch only ones
// - Alias reads return undefined, here zero
// - Aliases at offsets 4, 8, c
// - Analog select resets zero; 1 digital
// - Analog pins read zero, input disabled
// - Open drain only pulls low or releases
// - Reference output overrides direction bit
// - Change on selected pin raises request
// - Pull-up enabled only by its bit
module pio_port
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register request
    input wire pio_req_t req,
    output logic [15:0] rdata_q,
    output logic rvalid_q,
    // Pads
    input wire logic [15:0] pad_in,
    output pio_pad_t pad,
    // Comparator reference output
    input wire logic comparator_ref_output,
    input wire logic [15:0] ref_pin_mask,
    output logic [15:0] analog_out_en,
    // Change notification
    output logic cn_irq
);
    logic [15:0] direction_control_reg;
    logic [15:0] output_hold_reg;
    logic [15:0] open_drain_select;
    logic [15:0] analog_digital_select;
    logic [15:0] cn_enable;
    logic [15:0] change_pullup_enable;
    logic [15:0] sync1_q;
    logic [15:0] sync2_q;
    logic [15:0] prev_q;
    logic [15:0] cn_pend_q;
    logic [15:0] cn_pend_d;
    logic [15:0] pin_level;
    logic [7:0] base;
    pio_op_t op;
    logic we_dir;
    logic we_hold;
    logic we_ods;
    logic we_ads;
    logic we_cnen;
    logic we_pue;
    logic we_pend;

    // ==========================================================
    // Address decode
    // Alias offset selects operation
    always_comb begin
        base = {req.addr[7:4], 4'h0};
        if (req.addr[3:0] == PIO_ALIAS_CLR) begin
            op = PIO_OP_CLR;
        end else if (req.addr[3:0] == PIO_ALIAS_SET) begin
            op = PIO_OP_SET;
        end else if (req.addr[3:0] == PIO_ALIAS_INV) begin
            op = PIO_OP_INV;
        end else begin
            op = PIO_OP_WRITE;
        end
    end

    assign we_dir = req.wr && base == PIO_OFF_DIR;
    // Pin level writes land in hold
    assign we_hold = req.wr && (base == PIO_OFF_HOLD || base == PIO_OFF_LVL);
    assign we_ods = req.wr && base == PIO_OFF_ODS;
    assign we_ads = req.wr && base == PIO_OFF_ADS;
    assign we_cnen = req.wr && base == PIO_OFF_CNEN;
    assign we_pue = req.wr && base == PIO_OFF_PUE;
    assign we_pend = req.wr && base == PIO_OFF_CNPEND;

    // ==========================================================
    // Registers
    // Direction resets to all inputs
    pio_reg_bit #(.RST(PIO_RST_DIR), .MASK(PIO_IMPL_MASK)) u_dir (
        .ref_clk(ref_clk), .reset(reset), .we(we_dir), .op(op),
        .wdata(req.wdata), .value_q(direction_control_reg)
    );
    pio_reg_bit #(.RST(PIO_RST_HOLD), .MASK(PIO_IMPL_MASK)) u_hold (
        .ref_clk(ref_clk), .reset(reset), .we(we_hold), .op(op),
        .wdata(req.wdata), .value_q(output_hold_reg)
    );
    pio_reg_bit #(.RST(PIO_RST_ODS), .MASK(PIO_IMPL_MASK)) u_ods (
        .ref_clk(ref_clk), .reset(reset), .we(we_ods), .op(op),
        .wdata(req.wdata), .value_q(open_drain_select)
    );
    pio_reg_bit #(.RST(PIO_RST_ADS), .MASK(PIO_IMPL_MASK)) u_ads (
        .ref_clk(ref_clk), .reset(reset), .we(we_ads), .op(op),
        .wdata(req.wdata), .value_q(analog_digital_select)
    );
    pio_reg_bit #(.RST(PIO_RST_CNEN), .MASK(PIO_CN_MASK)) u_cnen (
        .ref_clk(ref_clk), .reset(reset), .we(we_cnen), .op(op),
        .wdata(req.wdata), .value_q(cn_enable)
    );
    pio_reg_bit #(.RST(PIO_RST_PUE), .MASK(PIO_CN_MASK)) u_pue (
        .ref_clk(ref_clk), .reset(reset), .we(we_pue), .op(op),
        .wdata(req.wdata), .value_q(change_pullup_enable)
    );

    // ==========================================================
    // Pin input path
    // Two-stage synchronizer
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= PIO_RST_ZERO;
            sync2_q <= PIO_RST_ZERO;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
        end
    end

    assign pin_level = sync2_q & analog_digital_select & PIO_IMPL_MASK;

    // ==========================================================
    // Change notification
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev_q <= PIO_RST_ZERO;
        end else begin
            prev_q <= pin_level;
        end
    end

    // Mismatch sets sticky flag, set beats clear
    always_comb begin
        cn_pend_d = cn_pend_q;
        if (we_pend) begin
            case (op)
                PIO_OP_CLR: cn_pend_d = cn_pend_q & ~req.wdata;
                PIO_OP_WRITE: cn_pend_d = req.wdata & cn_pend_q;
                default: cn_pend_d = cn_pend_q;
            endcase
        end
        cn_pend_d = cn_pend_d | ((pin_level ^ prev_q) & cn_enable);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cn_pend_q <= PIO_RST_ZERO;
        end else begin
            cn_pend_q <= cn_pend_d;
        end
    end

    assign cn_irq = |cn_pend_q;

    // ==========================================================
    // Pad drive
    // Zero direction bit drives pin
    always_comb begin
        pad.out = output_hold_reg & ~open_drain_select;
        pad.oe = ~direction_control_reg & PIO_IMPL_MASK
            & ~(open_drain_select & output_hold_reg) & ~analog_out_en;
        pad.pullup_en = change_pullup_enable & PIO_CN_MASK;
    end

    assign analog_out_en = comparator_ref_output ? (ref_pin_mask & PIO_IMPL_MASK) : 16'h0000;

    // ==========================================================
    // Read path, one cycle after request
    // Read mux
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= PIO_RST_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (!req.rd) begin
                rdata_q <= rdata_q;
            end else if (op != PIO_OP_WRITE) begin
                rdata_q <= PIO_ALIAS_RDATA;
            end else if (base == PIO_OFF_DIR) begin
                rdata_q <= direction_control_reg;
            end else if (base == PIO_OFF_LVL) begin
                rdata_q <= pin_level;
            end else if (base == PIO_OFF_HOLD) begin
                rdata_q <= output_hold_reg;
            end else if (base == PIO_OFF_ODS) begin
                rdata_q <= open_drain_select;
            end else if (base == PIO_OFF_ADS) begin
                rdata_q <= analog_digital_select;
            end else if (base == PIO_OFF_CNEN) begin
                rdata_q <= cn_enable;
            end else if (base == PIO_OFF_PUE) begin
                rdata_q <= change_pullup_enable;
            end else if (base == PIO_OFF_CNPEND) begin
                rdata_q <= cn_pend_q;
            end else begin
                rdata_q <= PIO_RST_ZERO;
            end
        end
    end

    // ==========================================================
    // Checks
    a_dir_reset: assert property (@(posedge ref_clk) $rose(!reset) |->
        direction_control_reg == PIO_IMPL_MASK)
        else $error("direction not all inputs after reset");
    a_ads_reset: assert property (@(posedge ref_clk) $fell(reset) |->
        analog_digital_select == PIO_RST_ADS)
        else $error("analog select not zero after reset");
    a_lvl_to_hold: assert property (@(posedge ref_clk) disable iff (reset)
        req.wr && req.addr == PIO_OFF_LVL |=> output_hold_reg == $past(req.wdata))
        else $error("pin level write missed hold");
    a_set_alias: assert property (@(posedge ref_clk) disable iff (reset)
        we_dir && op == PIO_OP_SET |=>
        direction_control_reg == ($past(direction_control_reg) | $past(req.wdata)))
        else $error("set alias wrong");
    a_analog_zero: assert property (@(posedge ref_clk) disable iff (reset)
        req.rd && req.addr == PIO_OFF_LVL |=>
        (rdata_q & ~$past(analog_digital_select)) == 16'h0000)
        else $error("analog pin read nonzero");
    // Open-drain pins drive only while hold is low, and never drive a one
    a_od_nohigh: assert property (@(posedge ref_clk) disable iff (reset)
        (((pad.oe & output_hold_reg) | pad.out) & open_drain_select) == 16'h0000)
        else $error("open drain drove high");
    a_dir_input: assert property (@(posedge ref_clk) disable iff (reset)
        (pad.oe & direction_control_reg) == 16'h0000)
        else $error("input pin driven");
    sequence s_pin_change;
        ((pin_level ^ prev_q) & cn_enable) != 16'h0000;
    endsequence
    a_cn_irq: assert property (@(posedge ref_clk) disable iff (reset)
        s_pin_change |=> cn_irq)
        else $error("change missed");
    // Check every cycle out of reset: sync2_q follows pad_in two cycles later
    a_sync_delay: assert property (@(posedge ref_clk) disable iff (reset)
        !reset |-> ##2 sync2_q == $past(pad_in, 2))
        else $error("sync depth wrong");
endmodule : pio_port
`default_nettype wire

// ### testbench/pio_pin_model.sv
// Pin-side model: outside drivers, weak pull-ups and the resolved pin levels.
// Assumes the bench changes ext_en and ext_val just after a clock edge.
`default_nettype none
module pio_pin_model
    import pio_pkg::*;
(
    // Pads from the port
    input wire pio_pad_t pad,
    input wire logic [15:0] analog_out_en,
    // Outside drivers
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    // Levels back to the port
    output logic [15:0] pad_in
);
    // ==========================================================
    // Wire level
    // Floating pins show the inverse of the last drive, not a lucky guess
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad_in[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] :
                (pad.pullup_en[i] | analog_out_en[i]) ? 1'b1 : ~ext_val[i];
        end
    end
endmodule : pio_pin_model
`default_nettype wire

// ### testbench/pio_port_bench.sv
// Self-checking bench for the parallel I/O port with a pin-side model.
// Assumes a 100 MHz clock and the register map of the package.
`default_nettype none
module pio_port_bench
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset;
    pio_req_t req;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic [15:0] pad_in;
    pio_pad_t pad;
    logic comparator_ref_output;
    logic [15:0] ref_pin_mask;
    logic [15:0] analog_out_en;
    logic cn_irq;
    logic [15:0] ext_en;
    logic [15:0] ext_val;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // ==========================================================
    // Clock, design and pins
    always #5 ref_clk = ~ref_clk;
    pio_port dut_u (.ref_clk(ref_clk), .reset(reset), .req(req), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .pad_in(pad_in), .pad(pad),
        .comparator_ref_output(comparator_ref_output), .ref_pin_mask(ref_pin_mask),
        .analog_out_en(analog_out_en), .cn_irq(cn_irq));
    pio_pin_model pins_u (.pad(pad), .analog_out_en(analog_out_en), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
        #1;
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        req <= '0;
        #1;
        chk("read valid", 16'h0001, {15'h0000, rvalid_q});
        chk(what, exp, rdata_q);
    endtask : rchk
    task automatic drive(input logic [15:0] en, input logic [15:0] val);
        @(posedge ref_clk);
        ext_en <= en;
        ext_val <= val;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : drive
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rchk("direction", PIO_OFF_DIR, 16'hffff);
        rchk("analog select", PIO_OFF_ADS, 16'h0000);
        chk("output enable", 16'h0000, pad.oe);
        $display("test reset done");
    endtask : t_reset
    task automatic t_hold();
        wr(PIO_OFF_LVL, 16'h5a3c);
        rchk("hold via level", PIO_OFF_HOLD, 16'h5a3c);
        wr(PIO_OFF_HOLD, 16'h1234);
        wr(PIO_OFF_DIR, 16'h0000);
        chk("pad out", 16'h1234, pad.out);
        chk("output enable", 16'hffff, pad.oe);
        $display("test hold done");
    endtask : t_hold
    task automatic t_alias();
        wr(PIO_OFF_HOLD + 8'h08, 16'h00f0);
        rchk("set alias", PIO_OFF_HOLD, 16'h12f4);
        wr(PIO_OFF_HOLD + 8'h04, 16'h1200);
        rchk("clear alias", PIO_OFF_HOLD, 16'h00f4);
        wr(PIO_OFF_HOLD + 8'h0c, 16'h00ff);
        rchk("toggle alias", PIO_OFF_HOLD, 16'h000b);
        rchk("alias read", PIO_OFF_HOLD + 8'h08, PIO_ALIAS_RDATA);
        $display("test alias done");
    endtask : t_alias
    task automatic t_level();
        wr(PIO_OFF_DIR, 16'hffff);
        wr(PIO_OFF_ADS, 16'hffff);
        drive(16'hffff, 16'ha5c3);
        rchk("pin level", PIO_OFF_LVL, 16'ha5c3);
        wr(PIO_OFF_ADS + 8'h04, 16'h00ff);
        rchk("analog level", PIO_OFF_LVL, 16'ha500);
        $display("test level done");
    endtask : t_level
    task automatic t_drain();
        drive(16'h0000, 16'h0000);
        wr(PIO_OFF_ADS, 16'hffff);
        wr(PIO_OFF_DIR, 16'h0000);
        wr(PIO_OFF_ODS, 16'h0001);
        wr(PIO_OFF_HOLD, 16'h0001);
        chk("drain released", 16'hfffe, pad.oe);
        chk("drain out", 16'h0000, pad.out);
        wr(PIO_OFF_HOLD + 8'h04, 16'h0001);
        chk("drain low", 16'hffff, pad.oe);
        @(posedge ref_clk);
        comparator_ref_output <= 1'b1;
        ref_pin_mask <= 16'h0003;
        @(posedge ref_clk);
        #1;
        chk("analog out", 16'h0003, analog_out_en);
        chk("analog oe", 16'hfffc, pad.oe);
        $display("test drain done");
    endtask : t_drain
    task automatic t_notify();
        drive(16'h0030, 16'h0010);
        wr(PIO_OFF_DIR + 8'h08, 16'hffff);
        rchk("direction set", PIO_OFF_DIR, 16'hffff);
        wr(PIO_OFF_CNEN, 16'h0010);
        wr(PIO_OFF_PUE, 16'h0010);
        chk("pull-up", 16'h0010, pad.pullup_en);
        wr(PIO_OFF_CNPEND, 16'h0000);
        drive(16'h0030, 16'h0030);
        chk("unselected change", 16'h0000, {15'h0000, cn_irq});
        drive(16'h0030, 16'h0020);
        chk("selected change", 16'h0001, {15'h0000, cn_irq});
        rchk("pending", PIO_OFF_CNPEND, 16'h0010);
        wr(PIO_OFF_CNPEND + 8'h04, 16'h0010);
        @(posedge ref_clk);
        #1;
        chk("pending cleared", 16'h0000, {15'h0000, cn_irq});
        $display("test notify done");
    endtask : t_notify
    // ==========================================================
    // Watchdog and main sequence
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        reset = 1'b1;
        req = '0;
        comparator_ref_output = 1'b0;
        ref_pin_mask = 16'h0000;
        ext_en = 16'h0000;
        ext_val = 16'h0000;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_hold();
        t_alias();
        t_level();
        t_drain();
        t_notify();
        stop_test();
    end
endmodule : pio_port_bench
`default_nettype wire
